// ### src/dq_term_pkg.sv
// Constants for the DQ write termination controller: APB map, field
// layout, latency tables and settle timing. Used by the controller, the checker and the bench.
package dq_term_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

    // termination_mode_register fields
    localparam int STRENGTH_LSB  = 0;
    localparam int STRENGTH_W    = 3;
    localparam int WL_SET_BIT    = 3;
    localparam int BL32_BIT      = 4;
    localparam int BAND_LSB      = 5;
    localparam int BAND_W        = 3;
    localparam int WLEVEL_BIT    = 8;
    localparam int CTRL_W        = 9;

    // Status fields
    localparam int ST_DQ_BIT     = 0;
    localparam int ST_DQS_BIT    = 1;
    localparam int ST_WIN_BIT    = 2;
    localparam int ST_BADBAND_BIT = 3;
    localparam int ST_LOWPWR_BIT = 4;

    // Strength codes: calib_reference_resistance divided by 1..6
    localparam logic [2:0] STRENGTH_OFF   = 3'h0;
    localparam logic [2:0] STRENGTH_MAXOK = 3'h6;

    // ----------------------------------------------------------------
    // Latencies in link clock cycles from CAS-2
    // ----------------------------------------------------------------
    localparam int LAT_W = 6;
    localparam logic [LAT_W-1:0] LAT_NA    = 6'h00;
    localparam logic [LAT_W-1:0] BL32_EXTRA = 6'h08;
    localparam logic [BAND_W-1:0] BAND_LAST = 3'h5;

    // Index = band (0: 533-800 MHz ... 5: 1866-2133 MHz)
    localparam logic [LAT_W-1:0] ON_SET_FIRST  [6] = '{6'h00, 6'h04, 6'h04, 6'h06, 6'h06, 6'h08};
    localparam logic [LAT_W-1:0] ON_SET_SECOND [6] = '{6'h06, 6'h0c, 6'h0e, 6'h12, 6'h14, 6'h18};
    localparam logic [LAT_W-1:0] OFF_SET_FIRST [6] = '{6'h00, 6'h14, 6'h16, 6'h18, 6'h1a, 6'h1c};
    localparam logic [LAT_W-1:0] OFF_SET_SECOND[6] = '{6'h16, 6'h1c, 6'h20, 6'h24, 6'h28, 6'h2c};

    // ----------------------------------------------------------------
    // Settle times (ps) and pclk cycles at 4 ns
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS        = 4000;
    localparam int TERM_ON_SETTLE_MIN_PS  = 1500;
    localparam int TERM_ON_SETTLE_MAX_PS  = 3500;
    localparam int TERM_OFF_SETTLE_MIN_PS = 1500;
    localparam int TERM_OFF_SETTLE_MAX_PS = 3500;
    localparam int ON_MIN_CYC  = (TERM_ON_SETTLE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ON_MAX_RAW  = TERM_ON_SETTLE_MAX_PS / CLK_PERIOD_PS;
    localparam int ON_MAX_CYC  = (ON_MAX_RAW < 1) ? 1 : ON_MAX_RAW;
    localparam int OFF_MIN_CYC = (TERM_OFF_SETTLE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int OFF_MAX_RAW = TERM_OFF_SETTLE_MAX_PS / CLK_PERIOD_PS;
    localparam int OFF_MAX_CYC = (OFF_MAX_RAW < 1) ? 1 : OFF_MAX_RAW;
    // Switch point takes the smaller of the two rounded cycle bounds
    localparam int ON_SETTLE_CYC  = (ON_MIN_CYC < ON_MAX_CYC) ? ON_MIN_CYC : ON_MAX_CYC;
    localparam int OFF_SETTLE_CYC = (OFF_MIN_CYC < OFF_MAX_CYC) ? OFF_MIN_CYC : OFF_MAX_CYC;
    localparam int SETTLE_W = 3;

    // Window tracking states
    typedef enum logic [1:0] {
        WIN_IDLE  = 2'b00,
        WIN_ARMED = 2'b01,
        WIN_COUNT = 2'b10
    } win_state_t;

endpackage : dq_term_pkg

// ### src/link_sync.sv
// Two-flop synchroniser bank for link pins entering the pclk domain.
// Assumes each bit is an independent level; no bus coherency kept.
`timescale 1ns/1ns
module link_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : link_sync

// ### src/dq_write_termination_control.sv
// DQ/DMI/DQS write termination controller with an APB register slave.
// Link pins (ck_link, cke, command strobes) are asynchronous to pclk;
// pclk must be fast enough to see every link clock edge.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns

// How it works
// - Non-zero strength field enables termination; zero disables it entirely.
// - Strength codes 1..6 select reference resistance divided by 1..6.
// - Termination applies to every DQ, DMI and both strobe pins.
// - Idle pins stay high impedance; Write-1 or Mask Write-1 arms termination.
// - After the burst, termination returns off with no further command.
// - On latency counts link cycles from CAS-2 per band and set.
// - Off latency counts link cycles from CAS-2 per band and set.
// - Burst length 32 adds eight cycles to the off latency.
// - Turn-on completes between 1.5 ns and 3.5 ns after on latency; the settle stage here is one 4 ns pclk.
// - Turn-off completes between 1.5 ns and 3.5 ns after off latency; the settle stage here is one 4 ns pclk.
// - Write leveling terminates strobes only, and only when enabled.
// - No data termination during power-down or self-refresh.
module dq_write_termination_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ck_link,
    input  wire logic        cke,
    input  wire logic        wr1_cmd,
    input  wire logic        cas2_cmd,
    input  wire logic        self_refresh,
    output logic             dq_term_en,
    output logic             dmi_term_en,
    output logic             dqs_term_en,
    output logic      [2:0]  term_resistance_sel
);

    // ----------------------------------------------------------------
    // Latency lookup
    // ----------------------------------------------------------------
    function automatic logic [dq_term_pkg::LAT_W-1:0] lat_lookup(
        input logic [dq_term_pkg::BAND_W-1:0] band,
        input logic                           set_second,
        input logic                           off_lat
    );
        logic [dq_term_pkg::LAT_W-1:0] v;
        v = dq_term_pkg::LAT_NA;
        if (band <= dq_term_pkg::BAND_LAST) begin
            if (off_lat) begin
                v = set_second ? dq_term_pkg::OFF_SET_SECOND[band]
                               : dq_term_pkg::OFF_SET_FIRST[band];
            end else begin
                v = set_second ? dq_term_pkg::ON_SET_SECOND[band]
                               : dq_term_pkg::ON_SET_FIRST[band];
            end
        end
        return v;
    endfunction : lat_lookup

    // ----------------------------------------------------------------
    // Link pin synchronisers and edge detect
    // ----------------------------------------------------------------
    logic [3:0] link_q;
    logic       ck_prev_r;

    link_sync #(
        .WIDTH (4)
    ) u_link_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({ck_link, cke, wr1_cmd, cas2_cmd}),
        .q       (link_q)
    );

    // Edge history resets low like the idle link clock, so no false edge
    wire ck_s       = link_q[3];
    wire cke_s      = link_q[2];
    wire wr1_s      = link_q[1];
    wire cas2_s     = link_q[0];
    wire ck_rise    = ck_s & ~ck_prev_r;
    wire wr1_seen   = ck_rise & wr1_s;
    wire cas2_seen  = ck_rise & cas2_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_prev_r <= 1'b0;
        end else begin
            ck_prev_r <= ck_s;
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic [dq_term_pkg::CTRL_W-1:0] ctrl_r;

    wire        hit_ctrl   = (paddr == dq_term_pkg::CTRL_OFFSET);
    wire        hit_status = (paddr == dq_term_pkg::STATUS_OFFSET);
    wire        apb_access = psel & penable;
    wire        ctrl_wr    = apb_access & pwrite & hit_ctrl;
    wire [31:0] status_word;
    wire [31:0] read_word  = hit_ctrl   ? {{(32 - dq_term_pkg::CTRL_W){1'b0}}, ctrl_r}
                           : hit_status ? status_word
                           : 32'h0000_0000;

    // Zero wait states keep the write-to-effect delay fixed
    assign pready  = 1'b1;
    assign pslverr = apb_access & ~(hit_ctrl | hit_status);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= dq_term_pkg::CTRL_RESET[dq_term_pkg::CTRL_W-1:0];
        end else if (ctrl_wr) begin
            ctrl_r <= pwdata[dq_term_pkg::CTRL_W-1:0];
        end
    end

    // Captured in setup so the word stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= read_word;
        end
    end

    // ----------------------------------------------------------------
    // Configuration decode
    // ----------------------------------------------------------------
    wire [2:0] strength   = ctrl_r[dq_term_pkg::STRENGTH_LSB +: dq_term_pkg::STRENGTH_W];
    wire [2:0] band       = ctrl_r[dq_term_pkg::BAND_LSB +: dq_term_pkg::BAND_W];
    wire       set_second = ctrl_r[dq_term_pkg::WL_SET_BIT];
    wire       bl32       = ctrl_r[dq_term_pkg::BL32_BIT];
    wire       wlevel     = ctrl_r[dq_term_pkg::WLEVEL_BIT];

    wire       term_enabled = (strength != dq_term_pkg::STRENGTH_OFF);
    wire       low_power    = ~cke_s | self_refresh;

    // on latency per band and set
    wire [5:0] on_lat  = lat_lookup(band, set_second, 1'b0);
    // off latency per band and set
    wire [5:0] off_base = lat_lookup(band, set_second, 1'b1);
    wire [5:0] off_lat = off_base + (bl32 ? dq_term_pkg::BL32_EXTRA : dq_term_pkg::LAT_NA);
    // Undefined bands (set A at lowest band too) never open a write window
    wire       band_bad = (on_lat == dq_term_pkg::LAT_NA);
    wire       can_run  = term_enabled & ~band_bad & ~low_power & ~wlevel;

    // ----------------------------------------------------------------
    // Write window tracking
    // ----------------------------------------------------------------
    // Count runs in link edges; pclk only times the settle stage
    dq_term_pkg::win_state_t   win_r;
    dq_term_pkg::win_state_t   win_nxt;
    logic [5:0]                lat_cnt_r;
    logic [5:0]                lat_cnt_nxt;
    logic                      term_tgt_r;
    logic                      term_tgt_nxt;
    logic [2:0]                settle_r;
    logic [2:0]                settle_nxt;
    logic                      win_on_r;
    logic                      win_on_nxt;

    // Next link edge index, compared against both latencies
    wire       counting = (win_r == dq_term_pkg::WIN_COUNT);
    wire [5:0] lat_next = lat_cnt_r + 6'h01;
    wire       on_hit   = counting & ck_rise & (lat_next == on_lat);
    wire       off_hit  = counting & ck_rise & (lat_next == off_lat);

    always_comb begin
        win_nxt      = win_r;
        lat_cnt_nxt  = lat_cnt_r;
        term_tgt_nxt = term_tgt_r;
        settle_nxt   = settle_r;
        win_on_nxt   = win_on_r;
        unique case (win_r)
            dq_term_pkg::WIN_IDLE: begin
                if (wr1_seen) begin
                    win_nxt = dq_term_pkg::WIN_ARMED;
                end
            end
            dq_term_pkg::WIN_ARMED: begin
                if (cas2_seen) begin
                    win_nxt     = dq_term_pkg::WIN_COUNT;
                    lat_cnt_nxt = 6'h00;
                end
            end
            dq_term_pkg::WIN_COUNT: begin
                // Back-to-back write restarts the count; pins stay on meanwhile
                if (cas2_seen && wr1_seen) begin
                    lat_cnt_nxt = 6'h00;
                end else if (ck_rise) begin
                    lat_cnt_nxt = lat_cnt_r + 6'h01;
                end
                if (wr1_seen) begin
                    win_nxt = dq_term_pkg::WIN_ARMED;
                end
                if (on_hit) begin
                    term_tgt_nxt = 1'b1;
                    settle_nxt   = 3'(dq_term_pkg::ON_SETTLE_CYC);
                end
                if (off_hit) begin
                    term_tgt_nxt = 1'b0;
                    settle_nxt   = 3'(dq_term_pkg::OFF_SETTLE_CYC);
                    win_nxt      = wr1_seen ? dq_term_pkg::WIN_ARMED : dq_term_pkg::WIN_IDLE;
                end
            end
            default: begin
                win_nxt = dq_term_pkg::WIN_IDLE;
            end
        endcase
        if (settle_r != 3'h0) begin
            settle_nxt = settle_r - 3'h1;
            if (settle_r == 3'h1) begin
                win_on_nxt = term_tgt_r;
            end
        end
        // Zero strength, undefined band, leveling or low power drops any window at once
        if (!can_run) begin
            win_nxt      = dq_term_pkg::WIN_IDLE;
            lat_cnt_nxt  = 6'h00;
            term_tgt_nxt = 1'b0;
            settle_nxt   = 3'h0;
            win_on_nxt   = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_r     <= dq_term_pkg::WIN_IDLE;
            lat_cnt_r <= 6'h00;
        end else begin
            win_r     <= win_nxt;
            lat_cnt_r <= lat_cnt_nxt;
        end
    end

    // settle stage
    // Settle rounds to one pclk: the clock is coarser than the
    // 1.5 ns to 3.5 ns window, so a faster pclk would track it closer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_tgt_r <= 1'b0;
            settle_r   <= 3'h0;
            win_on_r   <= 1'b0;
        end else begin
            term_tgt_r <= term_tgt_nxt;
            settle_r   <= settle_nxt;
            win_on_r   <= win_on_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Pin termination outputs
    // ----------------------------------------------------------------
    // leveling terminates strobes only
    wire       dqs_level = wlevel & term_enabled & ~low_power;
    wire       dq_nxt    = win_on_r & can_run;
    // resistance code; code 7 is not defined, held off
    wire [2:0] sel_nxt   = (strength <= dq_term_pkg::STRENGTH_MAXOK) ? strength : 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dq_term_en  <= 1'b0;
            dmi_term_en <= 1'b0;
            dqs_term_en <= 1'b0;
        end else begin
            // same window on DQ, DMI, DQS
            dq_term_en  <= dq_nxt;
            dmi_term_en <= dq_nxt;
            dqs_term_en <= dq_nxt | dqs_level;
        end
    end

    // Code follows the field even while idle, so it is ready at turn-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_resistance_sel <= 3'h0;
        end else begin
            term_resistance_sel <= sel_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Status word
    // ----------------------------------------------------------------
    // Live levels, no capture: a read shows the state at its setup cycle
    assign status_word = {27'h0,
                          low_power,
                          band_bad,
                          counting,
                          dqs_term_en,
                          dq_term_en};

endmodule : dq_write_termination_control

// ### sim/dq_term_properties.sv
// Checker for the DQ write termination controller, bound to its top.
// Assumes the register map and field layout of dq_term_pkg.
`timescale 1ns/1ns
module dq_term_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cke,
    input wire logic        self_refresh,
    input wire logic        dq_term_en,
    input wire logic        dmi_term_en,
    input wire logic        dqs_term_en,
    input wire logic [2:0]  term_resistance_sel
);
    logic [8:0] ctrl_r;
    wire        acc     = psel && penable;
    wire        hit     = paddr == dq_term_pkg::CTRL_OFFSET || paddr == dq_term_pkg::STATUS_OFFSET;
    wire        ctrl_wr = acc && pready && pwrite && paddr == dq_term_pkg::CTRL_OFFSET;
    wire        nz      = ctrl_r[2:0] != 3'h0;
    wire        wl      = ctrl_r[8];
    // Codes above the last legal one select no resistance
    wire [2:0]  exp_sel = (ctrl_r[2:0] <= dq_term_pkg::STRENGTH_MAXOK) ? ctrl_r[2:0] : 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctrl_r <= 9'h000;
        else if (ctrl_wr) ctrl_r <= pwdata[8:0];
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_settled; $stable(ctrl_r) [*3]; endsequence
    sequence s_rd_ctrl; psel && !penable && !pwrite && paddr == 8'h00 ##1 acc; endsequence

    property p_off_zero; (!nz) [*3] |-> !dq_term_en && !dqs_term_en; endproperty
    a_off_zero: assert property (p_off_zero) else $error("termination on at strength zero");
    property p_res_sel; s_settled |-> term_resistance_sel == exp_sel; endproperty
    a_res_sel: assert property (p_res_sel) else $error("resistance code wrong");
    property p_dmi; dmi_term_en == dq_term_en; endproperty
    a_dmi: assert property (p_dmi) else $error("mask pin termination differs");
    property p_dqs; dq_term_en |-> dqs_term_en; endproperty
    a_dqs: assert property (p_dqs) else $error("strobe termination missing");
    property p_wl; (wl && nz) [*4] |-> dqs_term_en && !dq_term_en; endproperty
    a_wl: assert property (p_wl) else $error("leveling termination wrong");
    property p_cke; (!cke) [*5] |-> !dq_term_en; endproperty
    a_cke: assert property (p_cke) else $error("termination on in power-down");
    property p_sref; self_refresh [*3] |-> !dq_term_en; endproperty
    a_sref: assert property (p_sref) else $error("termination on in self-refresh");
    property p_err; acc |-> pready && pslverr == !hit; endproperty
    a_err: assert property (p_err) else $error("bus response wrong");
    property p_rd_ctrl; s_rd_ctrl |-> prdata == {23'h0, ctrl_r}; endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("mode read data wrong");
endmodule : dq_term_properties

// ### sim/ctrl_model.sv
// Memory controller side: link clock with Write-1 and CAS-2 strobes.
// Assumes the bench calls frame from its main sequence.
`timescale 1ns/1ns
module ctrl_model (
    output logic       ck_link,
    output logic       wr1_cmd,
    output logic       cas2_cmd,
    output logic [7:0] lk_cnt
);
    initial begin
        ck_link  = 1'b0;
        wr1_cmd  = 1'b0;
        cas2_cmd = 1'b0;
        lk_cnt   = 8'h00;
    end
    // frame long enough for the set in use
    task automatic frame(input int n);
        #3;
        for (int i = 0; i < n; i++) begin
            wr1_cmd  = (i == 0);
            cas2_cmd = (i == 1);
            #80 ck_link = 1'b1;
            lk_cnt = (i == 1) ? 8'h00 : lk_cnt + 8'h01;
            #80 ck_link = 1'b0;
        end
    endtask : frame
endmodule : ctrl_model

// ### sim/dq_write_termination_control_test.sv
// Self-checking bench for the DQ write termination controller.
// Assumes ctrl_model on the link side and the checker bound below.
`timescale 1ns/1ns
module dq_write_termination_control_test;
    logic        pclk, presetn, psel, penable, pwrite, cke, self_refresh, pready, pslverr;
    logic        ck_link, wr1_cmd, cas2_cmd, dq_term_en, dmi_term_en, dqs_term_en, dq_last;
    logic [7:0]  paddr, lk_cnt;
    logic [31:0] pwdata, prdata;
    logic [2:0]  term_resistance_sel, str;
    logic [8:0]  nt;
    logic [33:0] an;
    logic [8:0]  tq[$];
    logic [33:0] aq[$];
    integer      seed = 32'h1fbe9b99;
    int          errors, compares, cyc;

    dq_write_termination_control u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .ck_link, .cke, .wr1_cmd, .cas2_cmd,
        .self_refresh, .dq_term_en, .dmi_term_en, .dqs_term_en, .term_resistance_sel);
    ctrl_model u_m (.ck_link, .wr1_cmd, .cas2_cmd, .lk_cnt);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic cmp_term(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_term

    task automatic cmp_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_bus

    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    function automatic logic [31:0] ctl(input logic [2:0] s, input logic set, input logic bl,
                                        input logic [2:0] bd, input logic wl);
        return {23'h0, wl, bd, bl, set, s};
    endfunction : ctl

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        aq.push_back({w, e});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Write burst; lp 1 drops cke, lp 2 enters self-refresh mid window
    task automatic win(input logic [2:0] bd, input logic set, input logic bl,
                       input logic [1:0] lp);
        logic [7:0] on, off;
        on  = set ? dq_term_pkg::ON_SET_SECOND[bd] : dq_term_pkg::ON_SET_FIRST[bd];
        off = set ? dq_term_pkg::OFF_SET_SECOND[bd] : dq_term_pkg::OFF_SET_FIRST[bd];
        off = off + (bl ? 8'h08 : 8'h00);
        str = 3'(($random(seed) & 32'h7fff) % 6 + 1);
        apb(1'b1, 8'h00, ctl(str, set, bl, bd, 1'b0), 33'h0);
        tq.push_back({1'b1, on});
        tq.push_back({1'b0, (lp != 2'h0) ? 8'hff : off});
        fork
            u_m.frame(int'(off) + 3);
            if (lp != 2'h0) begin
                wait (lk_cnt == on + 8'h02);
                @(posedge pclk);
                cke          <= (lp != 2'h1);
                self_refresh <= (lp == 2'h2);
            end
        join
        @(posedge pclk);
        cke          <= 1'b1;
        self_refresh <= 1'b0;
        repeat (20) @(posedge pclk);
        $display("window band %0d set %0d bl32 %0d mode %0d done", bd, set, bl, lp);
    endtask : win

    always @(posedge pclk) begin
        if (presetn === 1'b1 && dq_term_en !== dq_last) begin
            nt = (tq.size() != 0) ? tq.pop_front() : 9'h0fe;
            cmp_term("dq_term_en", {7'h0, nt[8]}, {7'h0, dq_term_en});
            if (nt[7:0] != 8'hff) cmp_term("link count", nt[7:0], lk_cnt);
        end
        dq_last <= dq_term_en;
    end

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            an = aq.pop_front();
            cmp_bus("pslverr", {31'h0, an[32]}, {31'h0, pslverr});
            if (!an[33]) cmp_bus("prdata", an[31:0], prdata);
        end
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, self_refresh, dq_last} = 6'h00;
        {cke, paddr, pwdata} = {1'b1, 8'h00, 32'h0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0, {1'b0, dq_term_pkg::CTRL_RESET});
        apb(1'b0, 8'h08, 32'h0, 33'h1_0000_0000);
        apb(1'b1, 8'h0c, 32'hffff_ffff, 33'h1_0000_0000);
        apb(1'b1, 8'h00, ctl(3'h1, 1'b1, 1'b0, 3'h1, 1'b0), 33'h0);
        apb(1'b1, 8'h04, 32'hffff_ffff, 33'h0);
        apb(1'b0, 8'h04, 32'h0, 33'h0);
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, 8'h00, ctl(3'(s), 1'b0, 1'b1, 3'h2, 1'b0), 33'h0);
            apb(1'b0, 8'h00, 32'h0, {1'b0, ctl(3'(s), 1'b0, 1'b1, 3'h2, 1'b0)});
        end
        $display("register test done");
        win(3'h1, 1'b0, 1'b0, 2'h0);
        win(3'h5, 1'b1, 1'b1, 2'h0);
        win(3'h0, 1'b1, 1'b0, 2'h0);
        win(3'h3, 1'b0, 1'b1, 2'h0);
        win(3'(($random(seed) & 32'h7fff) % 5 + 1), 1'b1, 1'b0, 2'h0);
        win(3'h1, 1'b1, 1'b0, 2'h1);
        win(3'h1, 1'b1, 1'b0, 2'h2);
        apb(1'b1, 8'h00, ctl(3'h0, 1'b1, 1'b0, 3'h1, 1'b0), 33'h0);
        u_m.frame(40);
        apb(1'b1, 8'h00, ctl(3'h3, 1'b1, 1'b0, 3'h6, 1'b0), 33'h0);
        u_m.frame(40);
        apb(1'b0, 8'h04, 32'h0, 33'h8);
        for (int w = 0; w < 2; w++) begin
            apb(1'b1, 8'h00, ctl(3'(2 * w), 1'b0, 1'b0, 3'h1, 1'b1), 33'h0);
            repeat (8) @(posedge pclk);
            apb(1'b0, 8'h04, 32'h0, {1'b0, 32'(2 * w)});
        end
        $display("disable and leveling test done");
        print_verdict();
    end
endmodule : dq_write_termination_control_test

bind dq_write_termination_control dq_term_properties u_props (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .cke, .self_refresh, .dq_term_en,
    .dmi_term_en, .dqs_term_en, .term_resistance_sel);
